// ---- trigger_channel_output_control.sv ----
// trigger, channel selection and output on/off control of a power module controller
//
// Contract
// - initiate arms one trigger when not continuous
// - continuous mode keeps trigger always armed
// - accepted trigger applies stored triggered levels
// - later triggers ignored until re-armed
// - continuous setting takes on/1 or off/0
// - device reset clears continuous setting
// - continuous query returns 1 or 0
// - catalog lists known channels, no rescan
// - select channel 1..31, later commands follow
// - selecting offline channel revives that supply
// - select query returns current channel
// - instrument state 0 zeroes, 1 restores
// - current query returns measured current
// - voltage query returns measured voltage
// - extra measure arguments set warning bit 13
// - outputs enabled after power-up
// - output off keeps levels, drives zero
// - output on restores saved levels
// - level queries report saved values while off
// - output command accepts channel list/range
// - trigger clears waiting flag, continuous re-sets
`timescale 1ns/1ns

module trigger_channel_output_control (
    input  wire logic                                  clock,
    input  wire logic                                  reset_n,
    input  wire logic [trigger_channel_pkg::ADDR_W-1:0] address,
    input  wire logic [trigger_channel_pkg::DATA_W-1:0] writeData,
    input  wire logic                                  writeStrobe,
    input  wire logic                                  readStrobe,
    output logic      [trigger_channel_pkg::DATA_W-1:0] readData,
    input  wire logic                                  groupExecute,
    input  wire logic [trigger_channel_pkg::NUM_CH-1:0] channelPresent,
    input  wire trigger_channel_pkg::levels_t          measured,
    output trigger_channel_pkg::levels_t               drive,
    output logic      [4:0]                            driveChannel,
    output logic      [trigger_channel_pkg::NUM_CH-1:0] outputEnable,
    output logic                                       waiting_for_trigger_flag,
    output logic                                       reviveStrobe,
    output logic      [4:0]                            reviveChannel,
    output logic                                       rescanStrobe
);

    localparam int LW = trigger_channel_pkg::LEVEL_W;
    localparam int NC = trigger_channel_pkg::NUM_CH;

    // ========================================================================
    // input synchronisers
    logic [NC-1:0] presentSync1_q;
    logic [NC-1:0] presentSync2_q;
    logic          getSync1_q;
    logic          getSync2_q;
    logic          getSync3_q;
    logic          getEdge;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            presentSync1_q <= '0;
            presentSync2_q <= '0;
            getSync1_q     <= 1'b0;
            getSync2_q     <= 1'b0;
            getSync3_q     <= 1'b0;
        end else begin
            presentSync1_q <= channelPresent;
            presentSync2_q <= presentSync1_q;
            getSync1_q     <= groupExecute;
            getSync2_q     <= getSync1_q;
            getSync3_q     <= getSync2_q;
        end
    end

    // group execute is a level on the pin; only its rising edge counts
    assign getEdge = getSync2_q && !getSync3_q;

    // ========================================================================
    // command decode
    trigger_channel_pkg::cmd_word_t cmd;
    trigger_channel_pkg::cmd_op_t   op;
    logic                           trigEvent;
    logic                           trigTake;
    logic                           selValid;

    assign cmd       = trigger_channel_pkg::cmd_word_t'(writeData);
    assign op        = (writeStrobe && address == trigger_channel_pkg::ADDR_CMD)
                       ? cmd.op : trigger_channel_pkg::OP_NONE;
    assign trigEvent = (op == trigger_channel_pkg::OP_TRIGGER) || getEdge;
    assign selValid  = (cmd.channel >= trigger_channel_pkg::CHAN_MIN)
                       && (cmd.channel <= trigger_channel_pkg::CHAN_MAX);

    // ========================================================================
    // control state
    logic            cont_q,     cont_d;
    logic            armed_q,    armed_d;
    logic [4:0]      sel_q,      sel_d;
    logic [NC-1:0]   known_q,    known_d;
    logic [NC-1:0]   outOn_q,    outOn_d;
    logic [NC-1:0]   outMask_q,  outMask_d;
    logic            err_q,      err_d;
    logic            warn_q,     warn_d;
    logic            revive_q,   revive_d;
    logic [4:0]      reviveCh_q, reviveCh_d;
    logic            rescan_q,   rescan_d;
    logic [LW-1:0]   progV_q [NC];
    logic [LW-1:0]   progV_d [NC];
    logic [LW-1:0]   progI_q [NC];
    logic [LW-1:0]   progI_d [NC];
    logic [LW-1:0]   trigV_q [NC];
    logic [LW-1:0]   trigV_d [NC];
    logic [LW-1:0]   trigI_q [NC];
    logic [LW-1:0]   trigI_d [NC];
    trigger_channel_pkg::levels_t drive_q, drive_d;

    assign trigTake = trigEvent && armed_q;

    always_comb begin
        cont_d     = cont_q;
        armed_d    = armed_q;
        sel_d      = sel_q;
        // supplies that drop off the field bus fall out of the catalog
        known_d    = known_q & presentSync2_q & trigger_channel_pkg::CHAN_MASK;
        outOn_d    = outOn_q;
        outMask_d  = outMask_q;
        revive_d   = 1'b0;
        reviveCh_d = reviveCh_q;
        rescan_d   = 1'b0;
        progV_d    = progV_q;
        progI_d    = progI_q;
        trigV_d    = trigV_q;
        trigI_d    = trigI_q;
        err_d      = (readStrobe && address == trigger_channel_pkg::ADDR_STATUS)
                     ? 1'b0 : err_q;
        warn_d     = (readStrobe && address == trigger_channel_pkg::ADDR_QUES)
                     ? 1'b0 : warn_q;

        if (trigTake) begin
            progV_d[sel_q] = trigV_q[sel_q];
            progI_d[sel_q] = trigI_q[sel_q];
            armed_d        = cont_q;
        end

        case (op)
            trigger_channel_pkg::OP_INIT_IMM: begin
                armed_d = 1'b1;
            end
            trigger_channel_pkg::OP_INIT_CONT: begin
                cont_d = cmd.flag;
                if (cmd.flag) begin
                    armed_d = 1'b1;
                end
            end
            trigger_channel_pkg::OP_RESET: begin
                cont_d   = 1'b0;
                armed_d  = 1'b0;
                known_d  = presentSync2_q & trigger_channel_pkg::CHAN_MASK;
                rescan_d = 1'b1;
            end
            trigger_channel_pkg::OP_SELECT: begin
                if (selValid) begin
                    sel_d = cmd.channel;
                    if (!known_q[cmd.channel]) begin
                        revive_d            = 1'b1;
                        reviveCh_d          = cmd.channel;
                        known_d[cmd.channel] = 1'b1;
                    end
                end else begin
                    err_d = 1'b1;
                end
            end
            trigger_channel_pkg::OP_INST_STATE: begin
                outOn_d[sel_q] = cmd.flag;
            end
            trigger_channel_pkg::OP_OUTPUT: begin
                if (cmd.multi) begin
                    outOn_d = cmd.flag ? (outOn_q | outMask_q) : (outOn_q & ~outMask_q);
                end else begin
                    outOn_d[sel_q] = cmd.flag;
                end
            end
            trigger_channel_pkg::OP_MEASURE: begin
                if (cmd.extra) begin
                    warn_d = 1'b1;
                end
            end
            default: begin
            end
        endcase

        if (writeStrobe) begin
            case (address)
                trigger_channel_pkg::ADDR_VPROG:   progV_d[sel_q] = writeData[LW-1:0];
                trigger_channel_pkg::ADDR_IPROG:   progI_d[sel_q] = writeData[LW-1:0];
                trigger_channel_pkg::ADDR_VTRIG:   trigV_d[sel_q] = writeData[LW-1:0];
                trigger_channel_pkg::ADDR_ITRIG:   trigI_d[sel_q] = writeData[LW-1:0];
                trigger_channel_pkg::ADDR_OUTMASK: begin
                    outMask_d = writeData & trigger_channel_pkg::CHAN_MASK;
                end
                default: begin
                end
            endcase
        end

        // programmed levels stay stored while the output is off; only the drive is zeroed
        if (outOn_q[sel_q]) begin
            drive_d.volt = progV_q[sel_q];
            drive_d.curr = progI_q[sel_q];
        end else begin
            drive_d.volt = trigger_channel_pkg::LEVEL_ZERO;
            drive_d.curr = trigger_channel_pkg::LEVEL_ZERO;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cont_q     <= 1'b0;
            armed_q    <= 1'b0;
            sel_q      <= trigger_channel_pkg::SEL_RESET;
            known_q    <= '0;
            outOn_q    <= trigger_channel_pkg::OUT_ON_RESET;
            outMask_q  <= '0;
            err_q      <= 1'b0;
            warn_q     <= 1'b0;
            revive_q   <= 1'b0;
            reviveCh_q <= trigger_channel_pkg::SEL_RESET;
            rescan_q   <= 1'b0;
            drive_q    <= '0;
            for (int i = 0; i < NC; i++) begin
                progV_q[i] <= '0;
                progI_q[i] <= '0;
                trigV_q[i] <= '0;
                trigI_q[i] <= '0;
            end
        end else begin
            cont_q     <= cont_d;
            armed_q    <= armed_d;
            sel_q      <= sel_d;
            known_q    <= known_d;
            outOn_q    <= outOn_d;
            outMask_q  <= outMask_d;
            err_q      <= err_d;
            warn_q     <= warn_d;
            revive_q   <= revive_d;
            reviveCh_q <= reviveCh_d;
            rescan_q   <= rescan_d;
            drive_q    <= drive_d;
            progV_q    <= progV_d;
            progI_q    <= progI_d;
            trigV_q    <= trigV_d;
            trigI_q    <= trigI_d;
        end
    end

    // ========================================================================
    // read port
    logic [trigger_channel_pkg::DATA_W-1:0] readData_q, readData_d;

    always_comb begin
        readData_d = '0;
        if (readStrobe) begin
            case (address)
                trigger_channel_pkg::ADDR_CONT:     readData_d[0]    = cont_q;
                trigger_channel_pkg::ADDR_SEL:      readData_d[4:0]  = sel_q;
                trigger_channel_pkg::ADDR_CATALOG:  readData_d       = known_q;
                trigger_channel_pkg::ADDR_VPROG:    readData_d[LW-1:0] = progV_q[sel_q];
                trigger_channel_pkg::ADDR_IPROG:    readData_d[LW-1:0] = progI_q[sel_q];
                trigger_channel_pkg::ADDR_VTRIG:    readData_d[LW-1:0] = trigV_q[sel_q];
                trigger_channel_pkg::ADDR_ITRIG:    readData_d[LW-1:0] = trigI_q[sel_q];
                trigger_channel_pkg::ADDR_MEASV:    readData_d[LW-1:0] = measured.volt;
                trigger_channel_pkg::ADDR_MEASI:    readData_d[LW-1:0] = measured.curr;
                trigger_channel_pkg::ADDR_STATUS: begin
                    readData_d[trigger_channel_pkg::STAT_WAIT_BIT]  = armed_q;
                    readData_d[trigger_channel_pkg::STAT_OUTON_BIT] = outOn_q[sel_q];
                    readData_d[trigger_channel_pkg::STAT_ERR_BIT]   = err_q;
                end
                trigger_channel_pkg::ADDR_QUES: begin
                    readData_d[trigger_channel_pkg::QUES_WARN_BIT] = warn_q;
                end
                trigger_channel_pkg::ADDR_OUTMASK:  readData_d = outMask_q;
                trigger_channel_pkg::ADDR_OUTSTATE: readData_d = outOn_q;
                default:                            readData_d = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readData_q <= '0;
        end else begin
            readData_q <= readData_d;
        end
    end

    // ========================================================================
    // outputs
    assign readData                 = readData_q;
    assign drive                    = drive_q;
    assign driveChannel             = sel_q;
    assign outputEnable             = outOn_q;
    assign waiting_for_trigger_flag = armed_q;
    assign reviveStrobe             = revive_q;
    assign reviveChannel            = reviveCh_q;
    assign rescanStrobe             = rescan_q;

    // ========================================================================
    // assertions
    // the two trigger-level guards skip cycles with a write, whose data could overwrite levels
    AST_INIT_ARMS: assert property (@(posedge clock) disable iff (!reset_n)
        (op == trigger_channel_pkg::OP_INIT_IMM) |=> waiting_for_trigger_flag)
        else $error("initiate did not arm trigger");

    AST_CONT_ARMED: assert property (@(posedge clock) disable iff (!reset_n)
        cont_q |-> armed_q)
        else $error("continuous mode but trigger not armed");

    AST_TRIG_APPLY: assert property (@(posedge clock) disable iff (!reset_n)
        (trigTake && !writeStrobe) ##1 outOn_q[sel_q]
        |=> drive.volt == $past(trigV_q[sel_q], 2))
        else $error("trigger did not apply triggered voltage");

    AST_TRIG_IGNORED: assert property (@(posedge clock) disable iff (!reset_n)
        (getEdge && !armed_q && !writeStrobe)
        |=> progV_q[sel_q] == $past(progV_q[sel_q]))
        else $error("unarmed trigger changed programmed level");

    AST_RESET_CONT: assert property (@(posedge clock) disable iff (!reset_n)
        (op == trigger_channel_pkg::OP_RESET) |=> !cont_q && rescanStrobe ##1 !rescanStrobe)
        else $error("device reset did not clear continuous mode");

    AST_CONT_READ: assert property (@(posedge clock) disable iff (!reset_n)
        (readStrobe && address == trigger_channel_pkg::ADDR_CONT)
        |=> readData == {31'h0000_0000, $past(cont_q)})
        else $error("continuous query returned wrong value");

    AST_SEL_TAKE: assert property (@(posedge clock) disable iff (!reset_n)
        (op == trigger_channel_pkg::OP_SELECT && selValid)
        |=> driveChannel == $past(cmd.channel))
        else $error("valid channel not selected");

    AST_REVIVE: assert property (@(posedge clock) disable iff (!reset_n)
        (op == trigger_channel_pkg::OP_SELECT && selValid && !known_q[cmd.channel])
        |=> reviveStrobe && reviveChannel == $past(cmd.channel) ##1 !reviveStrobe)
        else $error("offline channel not revived");

    AST_SEL_REJECT: assert property (@(posedge clock) disable iff (!reset_n)
        (op == trigger_channel_pkg::OP_SELECT && !selValid)
        |=> $stable(sel_q) && err_q)
        else $error("bad channel accepted or no error");

    AST_WARN: assert property (@(posedge clock) disable iff (!reset_n)
        (op == trigger_channel_pkg::OP_MEASURE && cmd.extra)
        ##1 !readStrobe
        ##1 (readStrobe && address == trigger_channel_pkg::ADDR_QUES)
        |=> readData[trigger_channel_pkg::QUES_WARN_BIT])
        else $error("warning bit missing after extra arguments");

    AST_OFF_ZERO: assert property (@(posedge clock) disable iff (!reset_n)
        !outOn_q[sel_q] |=> drive.volt == '0 && drive.curr == '0)
        else $error("output off but level driven");

    AST_TRIG_WAIT: assert property (@(posedge clock) disable iff (!reset_n)
        (trigTake && !cont_q && op != trigger_channel_pkg::OP_INIT_IMM
         && op != trigger_channel_pkg::OP_INIT_CONT) |=> !waiting_for_trigger_flag)
        else $error("waiting flag not cleared by trigger");

    AST_MEAS_CURR: assert property (@(posedge clock) disable iff (!reset_n)
        (readStrobe && address == trigger_channel_pkg::ADDR_MEASI)
        |=> readData == {16'h0000, $past(measured.curr)})
        else $error("current query did not return measurement");

endmodule // trigger_channel_output_control

// ---- trigger_channel_pkg.sv ----
// constants, command encodings and carriers for the trigger and channel control block
package trigger_channel_pkg;

    // ========================================================================
    // bus geometry
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int LEVEL_W = 16;
    localparam int NUM_CH  = 32;

    // ========================================================================
    // register offsets (byte addresses, one word each)
    localparam logic [ADDR_W-1:0] ADDR_CMD      = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONT     = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SEL      = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CATALOG  = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_VPROG    = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IPROG    = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_VTRIG    = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_ITRIG    = 8'h1C;
    localparam logic [ADDR_W-1:0] ADDR_MEASV    = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_MEASI    = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_QUES     = 8'h2C;
    localparam logic [ADDR_W-1:0] ADDR_OUTMASK  = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_OUTSTATE = 8'h34;

    // ========================================================================
    // field positions
    localparam int STAT_WAIT_BIT  = 0;
    localparam int STAT_OUTON_BIT = 1;
    localparam int STAT_ERR_BIT   = 2;
    localparam int QUES_WARN_BIT  = 13;

    // ========================================================================
    // channel limits and reset values
    localparam logic [4:0]        CHAN_MIN      = 5'h01;
    localparam logic [4:0]        CHAN_MAX      = 5'h1F;
    localparam logic [4:0]        SEL_RESET     = 5'h01;
    localparam logic [NUM_CH-1:0] CHAN_MASK     = 32'hFFFF_FFFE;
    localparam logic [NUM_CH-1:0] OUT_ON_RESET  = 32'hFFFF_FFFE;
    localparam logic [LEVEL_W-1:0] LEVEL_ZERO   = 16'h0000;

    // ========================================================================
    // command word written at ADDR_CMD
    typedef enum logic [3:0] {
        OP_NONE       = 4'h0,
        OP_INIT_IMM   = 4'h1,
        OP_INIT_CONT  = 4'h2,
        OP_TRIGGER    = 4'h3,
        OP_RESET      = 4'h4,
        OP_SELECT     = 4'h5,
        OP_INST_STATE = 4'h6,
        OP_OUTPUT     = 4'h7,
        OP_MEASURE    = 4'h8
    } cmd_op_t;

    typedef struct packed {
        logic [5:0] pad0;
        logic       multi;
        logic       extra;
        logic [2:0] pad1;
        logic [4:0] channel;
        logic [6:0] pad2;
        logic       flag;
        logic [3:0] pad3;
        cmd_op_t    op;
    } cmd_word_t;

    typedef struct packed {
        logic [LEVEL_W-1:0] volt;
        logic [LEVEL_W-1:0] curr;
    } levels_t;

endpackage

// ---- supply_bus_model.sv ----
// behavioural model of the power supplies standing on the field bus
`timescale 1ns/1ns

module supply_bus_model #(
    parameter logic [15:0] DROP = 16'h0002
) (
    input  wire logic                         clock,
    input  wire trigger_channel_pkg::levels_t drive,
    input  wire logic [31:0]                  poweredMask,
    output logic      [31:0]                  channelPresent,
    output trigger_channel_pkg::levels_t      measured
);
    // ========================================================================
    // presence and load
    // presence follows the supplies that the bench keeps powered
    assign channelPresent = poweredMask;

    // load pulls the output a little below the programmed level, so a
    // readback of the programmed value cannot pass for a measurement
    always_ff @(posedge clock) begin
        measured.volt <= (drive.volt > DROP) ? drive.volt - DROP : 16'h0000;
        measured.curr <= (drive.curr > DROP) ? drive.curr - DROP : 16'h0000;
    end
endmodule // supply_bus_model

// ---- tb_top.sv ----
// self-checking testbench of the trigger, channel and output control block
`timescale 1ns/1ns

module tb_top;
    // ========================================================================
    // signals
    logic                         clock = 1'b0;
    logic                         reset_n = 1'b0;
    logic [7:0]                   address = 8'h00;
    logic [31:0]                  writeData = 32'h0000_0000;
    logic                         writeStrobe = 1'b0;
    logic                         readStrobe = 1'b0;
    logic [31:0]                  readData;
    logic                         groupExecute = 1'b0;
    logic [31:0]                  channelPresent;
    logic [31:0]                  poweredMask = 32'h0000_000E;
    trigger_channel_pkg::levels_t measured;
    trigger_channel_pkg::levels_t drive;
    logic [4:0]                   driveChannel;
    logic [31:0]                  outputEnable;
    logic                         waitFlag;
    logic                         reviveStrobe;
    logic [4:0]                   reviveChannel;
    logic                         rescanStrobe;
    logic [31:0]                  rd;
    int                           errCount = 0;
    int                           nChecks = 0;
    int                           cycles = 0;
    localparam logic [31:0] VP = 32'h0000_0210, IP = 32'h0000_0040;
    localparam logic [31:0] VT = 32'h0000_0150, IT = 32'h0000_0030;

    always #5 clock = ~clock;

    trigger_channel_output_control i_dut (
        .clock(clock), .reset_n(reset_n), .address(address), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
        .groupExecute(groupExecute), .channelPresent(channelPresent),
        .measured(measured), .drive(drive), .driveChannel(driveChannel),
        .outputEnable(outputEnable), .waiting_for_trigger_flag(waitFlag),
        .reviveStrobe(reviveStrobe), .reviveChannel(reviveChannel),
        .rescanStrobe(rescanStrobe)
    );

    supply_bus_model i_model (
        .clock(clock), .drive(drive), .poweredMask(poweredMask),
        .channelPresent(channelPresent), .measured(measured)
    );

    // ========================================================================
    // tasks
    task automatic finalReport();
        $display("checks %0d, mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        nChecks++;
        if (seen !== expected) begin
            errCount++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        writeStrobe <= 1'b1; address <= a; writeData <= d;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask

    // read data stand only in the cycle after the read edge
    task automatic rdReg(input logic [7:0] a, input logic [31:0] expected);
        @(posedge clock);
        readStrobe <= 1'b1; address <= a;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1 check(readData, expected);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    function automatic logic [31:0] cmd(input trigger_channel_pkg::cmd_op_t op,
            input logic flag = 1'b0, input logic [4:0] ch = 5'h00,
            input logic extra = 1'b0, input logic multi = 1'b0);
        trigger_channel_pkg::cmd_word_t c;
        c = '0;
        c.op = op; c.flag = flag; c.channel = ch; c.extra = extra; c.multi = multi;
        return c;
    endfunction

    // a hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            finalReport();
        end
    end

    // ========================================================================
    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        rdReg(trigger_channel_pkg::ADDR_CONT, 32'h0000_0000);
        rdReg(trigger_channel_pkg::ADDR_SEL, 32'h0000_0001);
        rdReg(trigger_channel_pkg::ADDR_OUTSTATE, 32'hFFFF_FFFE);
        check({31'h0, waitFlag}, 32'h0000_0000);
        rdReg(8'h3C, 32'h0000_0000);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_RESET));
        idle(2);
        rdReg(trigger_channel_pkg::ADDR_CATALOG, 32'h0000_000E);
        poweredMask <= 32'h0000_000A;
        idle(4);
        rdReg(trigger_channel_pkg::ADDR_CATALOG, 32'h0000_000A);
        poweredMask <= 32'h0000_000E;
        idle(4);
        rdReg(trigger_channel_pkg::ADDR_CATALOG, 32'h0000_000A);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_SELECT, 1'b0, 5'h02));
        #1 check({26'h0, reviveStrobe, reviveChannel}, 32'h0000_0022);
        rdReg(trigger_channel_pkg::ADDR_SEL, 32'h0000_0002);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_SELECT, 1'b0, 5'h00));
        rdReg(trigger_channel_pkg::ADDR_SEL, 32'h0000_0002);
        rdReg(trigger_channel_pkg::ADDR_STATUS, 32'h0000_0006);
        check({27'h0, driveChannel}, 32'h0000_0002);
        wr(trigger_channel_pkg::ADDR_VPROG, VP);
        wr(trigger_channel_pkg::ADDR_IPROG, IP);
        wr(trigger_channel_pkg::ADDR_VTRIG, VT);
        wr(trigger_channel_pkg::ADDR_ITRIG, IT);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_TRIGGER));
        idle(3);
        check(drive, {VP[15:0], IP[15:0]});
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_INIT_IMM));
        idle(1);
        check({31'h0, waitFlag}, 32'h0000_0001);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_TRIGGER));
        idle(3);
        check(drive, {VT[15:0], IT[15:0]});
        check({31'h0, waitFlag}, 32'h0000_0000);
        wr(trigger_channel_pkg::ADDR_VPROG, VP);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_TRIGGER));
        idle(3);
        check(drive, {VP[15:0], IT[15:0]});
        groupExecute <= 1'b1;
        idle(6);
        groupExecute <= 1'b0;
        check(drive, {VP[15:0], IT[15:0]});
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_INIT_CONT, 1'b1));
        rdReg(trigger_channel_pkg::ADDR_CONT, 32'h0000_0001);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_INIT_IMM));
        idle(1);
        check({31'h0, waitFlag}, 32'h0000_0001);
        // pin trigger passes a two-stage synchroniser first
        groupExecute <= 1'b1;
        idle(6);
        groupExecute <= 1'b0;
        check(drive, {VT[15:0], IT[15:0]});
        check({31'h0, waitFlag}, 32'h0000_0001);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_INIT_CONT, 1'b0));
        rdReg(trigger_channel_pkg::ADDR_CONT, 32'h0000_0000);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_INIT_CONT, 1'b1));
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_RESET));
        rdReg(trigger_channel_pkg::ADDR_CONT, 32'h0000_0000);
        rdReg(trigger_channel_pkg::ADDR_MEASV, VT - 32'h2);
        rdReg(trigger_channel_pkg::ADDR_MEASI, IT - 32'h2);
        wr(trigger_channel_pkg::ADDR_CMD,
           cmd(trigger_channel_pkg::OP_MEASURE, 1'b0, 5'h00, 1'b1));
        rdReg(trigger_channel_pkg::ADDR_QUES, 32'h0000_2000);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_OUTPUT, 1'b0));
        idle(3);
        check(drive, 32'h0000_0000);
        rdReg(trigger_channel_pkg::ADDR_VPROG, VT);
        rdReg(trigger_channel_pkg::ADDR_OUTSTATE, 32'hFFFF_FFFA);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_OUTPUT, 1'b1));
        idle(3);
        check(drive, {VT[15:0], IT[15:0]});
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_INST_STATE, 1'b0));
        idle(3);
        check(drive, 32'h0000_0000);
        wr(trigger_channel_pkg::ADDR_CMD, cmd(trigger_channel_pkg::OP_INST_STATE, 1'b1));
        idle(3);
        check(drive, {VT[15:0], IT[15:0]});
        wr(trigger_channel_pkg::ADDR_OUTMASK, 32'h0000_00F0);
        wr(trigger_channel_pkg::ADDR_CMD,
           cmd(trigger_channel_pkg::OP_OUTPUT, 1'b0, 5'h00, 1'b0, 1'b1));
        rdReg(trigger_channel_pkg::ADDR_OUTSTATE, 32'hFFFF_FF0E);
        check(outputEnable, 32'hFFFF_FF0E);
        wr(trigger_channel_pkg::ADDR_CMD,
           cmd(trigger_channel_pkg::OP_OUTPUT, 1'b1, 5'h00, 1'b0, 1'b1));
        rdReg(trigger_channel_pkg::ADDR_OUTSTATE, 32'hFFFF_FFFE);
        finalReport();
    end
endmodule // tb_top
